/* File: design/mlt_pkg.sv */
// Constants for the MII latency and clock-edge timing block.
// Assumes a 200 MHz system clock samples all MII-side pins.
package mlt_pkg;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // Bit times in picoseconds at each rate
   localparam int unsigned BIT_100_PS = 10000;
   localparam int unsigned BIT_10_PS = 100000;
   // Latencies in bits, transmit ones in tenths of a bit time, as printed
   localparam int unsigned TX_LAT_100_TENTHS = 48;
   localparam int unsigned CRS_ON_100_BITS = 14;
   localparam int unsigned RXD_LAT_100_BITS = 19;
   localparam int unsigned RXD_FAST_100_BITS = 15;
   localparam int unsigned CRS_OFF_100_BITS = 19;
   localparam int unsigned TX_LAT_10_TENTHS = 58;
   // Derived cycle counts (typical figures, rounded down)
   localparam int unsigned TX_LAT_100_CYC = TX_LAT_100_TENTHS * BIT_100_PS / 10 / CLK_PERIOD_PS;
   localparam int unsigned CRS_ON_100_CYC = CRS_ON_100_BITS * BIT_100_PS / CLK_PERIOD_PS;
   localparam int unsigned RXD_LAT_100_CYC = RXD_LAT_100_BITS * BIT_100_PS / CLK_PERIOD_PS;
   localparam int unsigned RXD_FAST_100_CYC = RXD_FAST_100_BITS * BIT_100_PS / CLK_PERIOD_PS;
   localparam int unsigned CRS_OFF_100_CYC = CRS_OFF_100_BITS * BIT_100_PS / CLK_PERIOD_PS;
   localparam int unsigned TX_LAT_10_CYC = TX_LAT_10_TENTHS * BIT_10_PS / 10 / CLK_PERIOD_PS;
   // Delay line depth covers the longest latency
   localparam int unsigned DLY_DEPTH = 128;
   localparam int unsigned DLY_AW = 7;
   // Registers
   localparam logic [4:0] ADDR_PHY_CONTROL_ONE = 5'h09;
   localparam logic [4:0] ADDR_PHY_STATUS = 5'h1A;
   localparam int unsigned FAST_RXDV_BIT = 1;
   localparam int unsigned SPEED_100_BIT = 0;
   localparam logic [15:0] PHY_CONTROL_ONE_RST = 16'h0000;
   // Receive clock half periods in system cycles
   localparam int unsigned RXCLK_HALF_100_CYC = 4;
   localparam int unsigned RXCLK_HALF_10_CYC = 40;
   localparam logic [7:0] RXCLK_HALF_100 = 8'h04;
   localparam logic [7:0] RXCLK_HALF_10 = 8'h28;
endpackage

/* File: design/mlt_dly_if.sv */
// Interface carrying a delayed bit between the top and its delay line.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface mlt_dly_if;
   logic din;
   logic [6:0] tap;
   logic dout;
   modport src (output din, output tap, input dout);
   modport dly (input din, input tap, output dout);
endinterface

/* File: design/mlt_dly.sv */
// Tapped shift delay line for one bit, tap chosen at run time.
// Assumes tap is below the depth; one shift per system clock.
`timescale 1ns/1ps
module mlt_dly
   import mlt_pkg::*;
#(
   parameter int unsigned DEPTH = DLY_DEPTH
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   mlt_dly_if.dly d
);
   logic [DEPTH-1:0] line_ff;
   logic [DEPTH-1:0] nxt_line;

   // Shift the new sample in at the bottom
   always_comb begin
      nxt_line = {line_ff[DEPTH-2:0], d.din};
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_ff <= '0;
      end else begin
         line_ff <= nxt_line;
      end
   end

   // Tap 0 gives one cycle of delay
   assign d.dout = line_ff[d.tap];
endmodule

/* File: design/mlt_phy_timing.sv */
// MII-side latency model of a 10/100 transceiver: media delays, CRS, RX clock.
// Assumes all MII and media pins are asynchronous and synchronised here.
//
// Contract
// R1: At 100M the J group leaves the media 4.8 bits after TX_EN clock edge.
// R2: At 100M carrier sense rises 14 bits after J arrives on media.
// R3: At 100M receive data appears 19 bits after media, 15 when fast.
// R4: Bit 1 of control register 0x0009 turns fast receive-valid detection on.
// R5: At 100M carrier sense falls 19 bits after the T group arrives.
// R6: At 10M the controller launches transmit signals on transmit clock rising edge.
// R7: At 10M transmit enable and data are captured on transmit clock falling edge.
// R8: At 10M media output starts 5.8 bits after the capturing falling edge.
// R9: At 100M receive clock handover may stretch a phase, never shorten one.
// R10: At 10M receive clock handover stretches only the low phase.
// R11: Controller tolerates stretched receive clock periods during handover.
`timescale 1ns/1ps
module mlt_phy_timing
   import mlt_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   input wire logic tx_clk_i,
   input wire logic tx_en_i,
   input wire logic rx_sel_rec_i,
   input wire logic media_rx_i,
   input wire logic media_rx_end_i,
   output logic media_tx_o,
   output logic crs_o,
   output logic rx_dv_o,
   output logic rx_clk_o
);
   typedef enum logic [1:0] {MLT_IDLE, MLT_ON, MLT_END} mlt_crs_e;

   // Two-flop synchronisers for every MII and media pin, with a third flop for the transmit pins
   logic [4:0] s1_ff, s2_ff, s3_ff;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= {rx_sel_rec_i, media_rx_end_i, media_rx_i, tx_en_i, tx_clk_i};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   logic txc, txc_d, txen, mrx, mend, selrec;
   assign txc = s2_ff[0];
   assign txc_d = s3_ff[0];
   // Enable as it stood before the sampled clock edge; it may change on that very edge
   assign txen = s3_ff[1];
   assign mrx = s2_ff[2];
   assign mend = s2_ff[3];
   assign selrec = s2_ff[4];

   // Register file
   logic [15:0] ctl_ff, nxt_ctl;
   logic [15:0] rdata_ff, nxt_rdata;
   logic speed100, fast_rx;
   logic crs_q;
   always_comb begin
      nxt_ctl = ctl_ff;
      nxt_rdata = 16'h0000;
      if (reg_wr_i && reg_addr_i == ADDR_PHY_CONTROL_ONE) begin
         nxt_ctl = reg_wdata_i; // R4
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_PHY_CONTROL_ONE: nxt_rdata = ctl_ff;
            ADDR_PHY_STATUS: nxt_rdata = {13'h0000, selrec, rx_dv_o, crs_q};
            default: nxt_rdata = 16'h0000;
         endcase
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_ff <= PHY_CONTROL_ONE_RST;
         rdata_ff <= 16'h0000;
      end else begin
         ctl_ff <= nxt_ctl;
         rdata_ff <= nxt_rdata;
      end
   end
   assign reg_rdata_o = rdata_ff;
   assign speed100 = ctl_ff[SPEED_100_BIT];
   assign fast_rx = ctl_ff[FAST_RXDV_BIT]; // R4

   // Transmit capture edge depends on rate; 10M uses the falling edge
   logic tx_rise, tx_fall, tx_cap;
   logic txen_cap_ff, nxt_txen_cap;
   assign tx_rise = txc & ~txc_d;
   assign tx_fall = ~txc & txc_d;
   assign tx_cap = speed100 ? tx_rise : tx_fall; // R7
   always_comb begin
      nxt_txen_cap = txen_cap_ff;
      if (tx_cap) begin
         nxt_txen_cap = txen; // R7
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         txen_cap_ff <= 1'b0;
      end else begin
         txen_cap_ff <= nxt_txen_cap;
      end
   end

   // Delay lines: transmit, receive data
   mlt_dly_if tx_if();
   mlt_dly_if rx_if();
   assign tx_if.din = txen_cap_ff;
   assign tx_if.tap = speed100 ? 7'(TX_LAT_100_CYC - 1) : 7'(TX_LAT_10_CYC - 1); // R1 R8
   assign rx_if.din = mrx;
   assign rx_if.tap = fast_rx ? 7'(RXD_FAST_100_CYC - 1) : 7'(RXD_LAT_100_CYC - 1); // R3
   mlt_dly #(.DEPTH(DLY_DEPTH)) u_tx_dly (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .d(tx_if));
   mlt_dly #(.DEPTH(DLY_DEPTH)) u_rx_dly (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .d(rx_if));

   logic mtx_ff, dv_ff;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mtx_ff <= 1'b0;
         dv_ff <= 1'b0;
      end else begin
         mtx_ff <= tx_if.dout;
         dv_ff <= rx_if.dout & crs_q;
      end
   end
   assign media_tx_o = mtx_ff;
   assign rx_dv_o = dv_ff;

   // Carrier sense: counted on and off delays from J and T arrival
   mlt_crs_e st_ff, nxt_st;
   logic [7:0] ccnt_ff, nxt_ccnt;
   logic crs_ff, nxt_crs;
   logic mrx_d_ff;
   always_comb begin
      nxt_st = st_ff;
      nxt_ccnt = ccnt_ff;
      nxt_crs = crs_ff;
      case (st_ff)
         MLT_IDLE: begin
            if (mrx && !mrx_d_ff) begin
               nxt_st = MLT_ON;
               nxt_ccnt = 8'(CRS_ON_100_CYC - 2);
            end
         end
         MLT_ON: begin
            if (ccnt_ff == 8'h00) begin
               nxt_crs = 1'b1; // R2
               if (mend) begin
                  nxt_st = MLT_END;
                  nxt_ccnt = 8'(CRS_OFF_100_CYC - 2);
               end
            end else begin
               nxt_ccnt = ccnt_ff - 8'h01;
            end
         end
         MLT_END: begin
            if (ccnt_ff == 8'h00) begin
               nxt_crs = 1'b0; // R5
               nxt_st = MLT_IDLE;
            end else begin
               nxt_ccnt = ccnt_ff - 8'h01;
            end
         end
         default: nxt_st = MLT_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= MLT_IDLE;
         ccnt_ff <= 8'h00;
         crs_ff <= 1'b0;
         mrx_d_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         ccnt_ff <= nxt_ccnt;
         crs_ff <= nxt_crs;
         mrx_d_ff <= mrx;
      end
   end
   assign crs_q = crs_ff;
   assign crs_o = crs_ff;

   // Receive clock generator; a source switch only restarts a phase so no phase shortens
   logic rck_ff, nxt_rck;
   logic [7:0] rcnt_ff, nxt_rcnt;
   logic sel_d_ff;
   logic [7:0] half;
   assign half = speed100 ? RXCLK_HALF_100 : RXCLK_HALF_10;
   always_comb begin
      nxt_rck = rck_ff;
      nxt_rcnt = rcnt_ff + 8'h01;
      if (selrec != sel_d_ff && (speed100 || !rck_ff)) begin
         nxt_rcnt = 8'h00; // R9 R10
      end else if (rcnt_ff >= half - 8'h01) begin
         nxt_rck = ~rck_ff;
         nxt_rcnt = 8'h00;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rck_ff <= 1'b0;
         rcnt_ff <= 8'h00;
         sel_d_ff <= 1'b0;
      end else begin
         rck_ff <= nxt_rck;
         rcnt_ff <= nxt_rcnt;
         sel_d_ff <= (speed100 || !rck_ff) ? selrec : sel_d_ff;
      end
   end
   assign rx_clk_o = rck_ff;

   // Phase length tracking for checks; a phase that spans a rate change is left out of the 10M high-phase check only
   logic [7:0] ph_ff;
   logic spd_d_ff, mix_ff;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ph_ff <= 8'h00;
         spd_d_ff <= 1'b0;
         mix_ff <= 1'b0;
      end else begin
         ph_ff <= (rck_ff != nxt_rck) ? 8'h00 : ph_ff + 8'h01;
         spd_d_ff <= speed100;
         mix_ff <= (rck_ff != nxt_rck) ? 1'b0 : (mix_ff | (speed100 != spd_d_ff));
      end
   end

   a_crs_on_delay: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R2
      (st_ff == MLT_IDLE && nxt_st == MLT_ON) |-> ##28 crs_ff)
      else $error("carrier sense on delay wrong");
   a_crs_off_delay: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R5
      (st_ff == MLT_ON && nxt_st == MLT_END) |-> ##1 crs_ff [*8] ##30 !crs_ff)
      else $error("carrier sense off delay wrong");
   a_fast_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R4
      (reg_wr_i && reg_addr_i == ADDR_PHY_CONTROL_ONE) |=> fast_rx == $past(reg_wdata_i[1]))
      else $error("fast bit not taken");
   a_rx_fast: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R3
      (st_ff == MLT_IDLE && nxt_st == MLT_ON && fast_rx) |-> ##30 !rx_dv_o ##1 rx_dv_o)
      else $error("fast receive data latency wrong");
   a_rx_normal: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R3
      (st_ff == MLT_IDLE && nxt_st == MLT_ON && !fast_rx) |-> ##38 !rx_dv_o ##1 rx_dv_o)
      else $error("normal receive data latency wrong");
   a_tx100_lat: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R1
      (speed100 && $rose(txen_cap_ff) && $stable(ctl_ff)) |-> ##10 (media_tx_o || !speed100))
      else $error("100M transmit latency wrong");
   a_tx10_lat: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R8
      (!speed100 && $rose(txen_cap_ff)) |-> ##117 (media_tx_o || speed100))
      else $error("10M transmit latency wrong");
   a_tx_edge: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R7
      (!speed100 && !tx_fall && !$stable(nxt_txen_cap)) |-> 1'b0)
      else $error("10M capture off falling edge");
   a_phase_min: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R9
      (rck_ff != nxt_rck) |-> ph_ff >= half - 8'h01)
      else $error("receive clock phase shortened");
   a_high_fixed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R10
      (!mix_ff && !speed100 && rck_ff && rck_ff != nxt_rck) |-> ph_ff == half - 8'h01)
      else $error("10M high phase stretched");
   c_crs_frame: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $fell(crs_ff));
   c_fast_dv: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) fast_rx && $rose(dv_ff));
   c_tx10: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) !speed100 && $rose(mtx_ff));
   c_handover: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) selrec != sel_d_ff);
endmodule

/* File: bench/mlt_mac_model.sv */
// Behavioural controller on the far side of the MII timing block.
// Assumes the bench raises frame_i to send and lowers it to end a frame.
`timescale 1ns/1ps
module mlt_mac_model (
   input wire logic frame_i,
   input wire logic rx_clk_i,
   output logic tx_clk_o,
   output logic tx_en_o,
   output int rx_edges_o
);
   initial begin
      tx_clk_o = 1'b0;
      tx_en_o = 1'b0;
      rx_edges_o = 0;
   end
   // Link clock runs inside a frame and for two periods past its end, phase unrelated to the system clock
   always @(posedge frame_i) begin
      #1.3;
      while (frame_i) begin
         #40 tx_clk_o = 1'b1;
         tx_en_o <= 1'b1;
         #40 tx_clk_o = 1'b0;
      end
      #40 tx_clk_o = 1'b1;
      tx_en_o <= 1'b0;
      #40 tx_clk_o = 1'b0;
      // One more rising edge so a rising-edge capture also sees the enable low
      #40 tx_clk_o = 1'b1;
      #40 tx_clk_o = 1'b0;
   end
   // Any stretched period is just a later edge; nothing is lost or doubled
   always @(posedge rx_clk_i) begin
      rx_edges_o <= rx_edges_o + 1;
   end
endmodule

/* File: bench/mlt_phy_timing_test.sv */
// Self-checking bench for the MII latency and clock-edge timing block.
// Assumes the controller model drives the transmit pins.
`timescale 1ns/1ps
module mlt_phy_timing_test;
   import mlt_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_pend = 1'b0;
   logic sel_rec = 1'b0;
   logic m_rx = 1'b0;
   logic m_rx_end = 1'b0;
   logic frame = 1'b0;
   logic spd100 = 1'b0;
   logic chk_rx = 1'b0;
   logic rx_clk_q = 1'b0;
   logic [15:0] w;
   logic [15:0] exp_q[$];
   int run = 0;
   int rx_edges;
   int miscompares = 0;
   int n_compared = 0;
   wire logic [15:0] rdata;
   wire logic tx_clk, tx_en, media_tx, crs, rx_dv, rx_clk;
   always #2.5 clk = ~clk;
   mlt_phy_timing uut (.clk_sys_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .tx_clk_i(tx_clk), .tx_en_i(tx_en), .rx_sel_rec_i(sel_rec), .media_rx_i(m_rx),
      .media_rx_end_i(m_rx_end), .media_tx_o(media_tx), .crs_o(crs), .rx_dv_o(rx_dv),
      .rx_clk_o(rx_clk));
   mlt_mac_model mac (.frame_i(frame), .rx_clk_i(rx_clk), .tx_clk_o(tx_clk),
      .tx_en_o(tx_en), .rx_edges_o(rx_edges));
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task rng(input string what, input int n, input int lo);
      check(what, 16'(n), (n >= lo && n <= lo + 7) ? 16'(n) : 16'(lo));
   endtask
   task give_verdict;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One bus cycle per edge; a read notes its expected data
   task bus(input logic w_n, input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w_n;
      rd <= ~w_n;
      if (!w_n) exp_q.push_back(d);
   endtask
   task idle;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_pend) check("rdata", rdata, exp_q.pop_front());
      rd_pend <= rd;
   end
   // Receive clock phases: never short, and at 10M only low may stretch
   always @(posedge clk) begin
      if (rx_clk !== rx_clk_q) begin
         if (chk_rx) check("rx phase", run >= (spd100 ? RXCLK_HALF_100_CYC : RXCLK_HALF_10_CYC)
            && (spd100 || !rx_clk_q || run == RXCLK_HALF_10_CYC), 1'b1);
         run <= 1;
      end else run <= run + 1;
      rx_clk_q <= rx_clk;
   end
   task tx_lat(input logic f);
      int n;
      n = 0;
      frame <= 1'b1;
      @(posedge tx_en);
      if (f) @(posedge tx_clk);
      else @(negedge tx_clk);
      while (media_tx !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      rng("tx start", n, f ? TX_LAT_100_CYC : TX_LAT_10_CYC);
      repeat ($urandom_range(4, 12)) @(posedge tx_clk);
      frame <= 1'b0;
      repeat (400) @(posedge clk);
      check("tx end", {15'h0000, media_tx}, 16'h0000);
   endtask
   task rx_frame(input logic fast);
      int n, tc, td;
      tc = -1;
      td = -1;
      @(posedge clk);
      m_rx <= 1'b1;
      for (n = 1; n <= 80; n++) begin
         @(posedge clk);
         if (crs === 1'b1 && tc < 0) tc = n;
         if (rx_dv === 1'b1 && td < 0) td = n;
      end
      rng("crs on", tc, CRS_ON_100_CYC);
      rng("rx_dv on", td, fast ? RXD_FAST_100_CYC : RXD_LAT_100_CYC);
      // Mid-frame status: carrier and receive valid up, reference clock selected
      bus(1'b0, ADDR_PHY_STATUS, 16'h0003);
      idle();
      m_rx_end <= 1'b1;
      n = 0;
      while (crs !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      rng("crs off", n, CRS_OFF_100_CYC);
      m_rx_end <= 1'b0;
      m_rx <= 1'b0;
      repeat (60) @(posedge clk);
   endtask
   task handover(input int span);
      repeat (8) begin
         repeat ($urandom_range(3, span)) @(posedge clk);
         sel_rec <= ~sel_rec;
      end
   endtask
   initial begin
      #200us;
      miscompares++;
      give_verdict();
   end
   initial begin
      void'($urandom(83231));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      w = 16'($urandom) | 16'h0001;
      bus(1'b0, ADDR_PHY_CONTROL_ONE, PHY_CONTROL_ONE_RST);
      bus(1'b1, ADDR_PHY_CONTROL_ONE, w);
      bus(1'b0, ADDR_PHY_CONTROL_ONE, w);
      bus(1'b1, 5'h05, 16'hFFFF);
      bus(1'b0, 5'h05, 16'h0000);
      bus(1'b0, ADDR_PHY_CONTROL_ONE, w);
      idle();
      spd100 <= 1'b1;
      repeat (100) @(posedge clk);
      chk_rx <= 1'b1;
      tx_lat(1'b1);
      rx_frame(w[1]);
      bus(1'b1, ADDR_PHY_CONTROL_ONE, w ^ 16'h0002);
      idle();
      rx_frame(~w[1]);
      handover(30);
      chk_rx <= 1'b0;
      bus(1'b1, ADDR_PHY_CONTROL_ONE, 16'h0000);
      idle();
      spd100 <= 1'b0;
      repeat (300) @(posedge clk);
      chk_rx <= 1'b1;
      tx_lat(1'b0);
      handover(120);
      repeat (200) @(posedge clk);
      check("rx edges", 16'(rx_edges > 0), 16'h0001);
      give_verdict();
   end
endmodule
